// File: rtl/ccp_pkg.sv
// Package with register map, mode codes and field layout of the capture/compare/PWM unit
package ccp_pkg;

  // ----------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] DUTY_OFF = 8'h04;
  localparam logic [7:0] TIMER_OFF = 8'h08;
  localparam logic [7:0] CMP_OFF = 8'h0c;
  localparam logic [7:0] CAPT_OFF = 8'h10;
  localparam logic [7:0] STATUS_OFF = 8'h14;
  localparam logic [7:0] PERIOD_OFF = 8'h18;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int MODE_LSB = 0;
  localparam int DUTY_LSB_POS = 4;
  localparam int OUTCFG_POS = 6;
  localparam int ADC_EN_POS = 8;
  localparam int TSEL_POS = 9;

  // ----------------------------------------
  // Reset values and the reverse bridge config code
  // ----------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [15:0] PERIOD_RST = 16'h00ff;
  localparam logic [1:0] CFG_REVERSE = 2'h3;

  // ----------------------------------------
  // Mode codes
  // ----------------------------------------
  localparam logic [3:0] M_OFF = 4'h0;
  localparam logic [3:0] M_CMP_TOG = 4'h2;
  localparam logic [3:0] M_CAP_FALL = 4'h4;
  localparam logic [3:0] M_CAP_RISE = 4'h5;
  localparam logic [3:0] M_CAP_R4 = 4'h6;
  localparam logic [3:0] M_CAP_R16 = 4'h7;
  localparam logic [3:0] M_CMP_SET = 4'h8;
  localparam logic [3:0] M_CMP_CLR = 4'h9;
  localparam logic [3:0] M_CMP_FLAG = 4'ha;
  localparam logic [3:0] M_CMP_SPEC = 4'hb;
  localparam logic [3:0] M_PWM_HH = 4'hc;
  localparam logic [3:0] M_PWM_HL = 4'hd;
  localparam logic [3:0] M_PWM_LH = 4'he;
  localparam logic [3:0] M_PWM_LL = 4'hf;

  // Prescale terminal counts for divided capture
  localparam logic [3:0] PRE4_LAST = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hf;

endpackage

// File: rtl/ccp_unit.sv
// Capture/compare/PWM unit with AHB-Lite register access
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
// Contract
// [R01] PWM duty is high byte over two low bits; low bits unused otherwise.
// [R02] Mode 0000 turns everything off and resets the unit.
// [R03] Software never writes reserved modes 0001 or 0011.
// [R04] Mode 0010: compare toggles output pin on match, sets flag.
// [R05] Mode 0100: capture on every falling input edge.
// [R06] Mode 0101: capture on every rising input edge.
// [R07] Mode 0110: capture once per four rising edges.
// [R08] Mode 0111: capture once per sixteen rising edges.
// [R09] Mode 1001: compare drives output pin low on match, sets flag.
// [R10] Mode 1010: compare sets flag only, pin unchanged.
// [R11] Mode 1011: special event sets flag, resets timer, may start conversion.
// [R12] Mode 1100: PWM, outputs A to D all active high.
// [R13] Mode 1111: PWM, outputs A to D all active low.
// [R14] Config 11: reverse full bridge, B modulated, C active, A,D inactive.
// [R15] Mode 1000: compare drives output pin high on match, sets flag.
// [R16] Mode 1101 A,C high B,D low; 1110 the opposite.
module ccp_unit (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic capture_pin,
  output logic unit_output_pin,
  output logic output_a,
  output logic output_b,
  output logic output_c,
  output logic output_d,
  output logic timer_reset,
  output logic adc_start
);

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic [31:0] ctrl_r;
  logic [7:0] duty_high_byte;
  logic [15:0] cmp_r;
  logic [15:0] period_r;
  logic [15:0] timer_r;
  logic [15:0] capt_r;
  logic match_event_flag;
  logic capt_flag_r;
  logic [3:0] unit_mode_field;
  logic [1:0] duty_low;
  logic [1:0] outcfg;
  logic bus_take;
  logic wr_now;
  logic clr_match;
  logic clr_capt;
  logic status_wr;
  logic pwm_active;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic cap_s1_r;
  logic cap_s2_r;
  logic cap_s3_r;

  // Zero wait states: every register answers in the cycle after its address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus_take = hsel && hready && htrans[1];
  assign wr_now = wr_pend_r;
  assign unit_mode_field = ctrl_r[ccp_pkg::MODE_LSB +: 4];
  assign duty_low = ctrl_r[ccp_pkg::DUTY_LSB_POS +: 2];
  assign outcfg = ctrl_r[ccp_pkg::OUTCFG_POS +: 2];
  // The match and capture flags (status bits 0 and 1) are cleared by writing one
  assign status_wr = wr_now && addr_r == ccp_pkg::STATUS_OFF;
  assign clr_match = status_wr && hwdata[0];
  assign clr_capt = status_wr && hwdata[1];
  assign pwm_active = unit_mode_field[3:2] == 2'h3;
  // The pin level is read behind the synchroniser, never straight from the pad
  assign status_word = {27'h0, unit_output_pin, pwm_active, cap_s2_r, capt_flag_r,
    match_event_flag};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else begin
      wr_pend_r <= bus_take && hwrite;
      if (bus_take) begin
        addr_r <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= ccp_pkg::CTRL_RST;
      duty_high_byte <= ccp_pkg::DUTY_RST;
      cmp_r <= 16'h0000;
      period_r <= ccp_pkg::PERIOD_RST;
    end else if (wr_now) begin
      // Writes land at the end of the data phase, when hwdata stands
      case (addr_r)
        ccp_pkg::CTRL_OFF: ctrl_r <= {22'h000000, hwdata[9:0]};
        ccp_pkg::DUTY_OFF: duty_high_byte <= hwdata[7:0];
        ccp_pkg::CMP_OFF: cmp_r <= hwdata[15:0];
        ccp_pkg::PERIOD_OFF: period_r <= hwdata[15:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Read data registered at the address phase so it stands in the data phase
  always_comb begin
    case (haddr)
      ccp_pkg::CTRL_OFF: rd_mux = ctrl_r;
      ccp_pkg::DUTY_OFF: rd_mux = {24'h000000, duty_high_byte};
      ccp_pkg::TIMER_OFF: rd_mux = {16'h0000, timer_r};
      ccp_pkg::CMP_OFF: rd_mux = {16'h0000, cmp_r};
      ccp_pkg::CAPT_OFF: rd_mux = {16'h0000, capt_r};
      ccp_pkg::STATUS_OFF: rd_mux = status_word;
      ccp_pkg::PERIOD_OFF: rd_mux = {16'h0000, period_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_take && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic unit_off;
  logic cap_en;
  logic cap_fall;
  logic [3:0] cap_last;
  logic cmp_en;
  logic [1:0] cmp_action;
  logic cmp_special;
  logic pwm_en;
  logic [3:0] pwm_invert;

  mode_decoder u_dec (
    .unit_mode_field(unit_mode_field),
    .unit_off(unit_off),
    .cap_en(cap_en),
    .cap_fall(cap_fall),
    .cap_last(cap_last),
    .cmp_en(cmp_en),
    .cmp_action(cmp_action),
    .cmp_special(cmp_special),
    .pwm_en(pwm_en),
    .pwm_invert(pwm_invert)
  );

  // ----------------------------------------
  // Timebase
  // ----------------------------------------
  logic timer_wrap;
  logic cmp_match;
  logic prev_match_r;

  // A period written below the running count restarts it at once, not after a full roll
  assign timer_wrap = timer_r >= period_r;
  assign cmp_match = cmp_en && timer_r == cmp_r;

  // Stands in for the neighbouring timer; the special event clears it too
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_r <= 16'h0000;
    end else if (unit_off) begin
      timer_r <= 16'h0000; // see [R02]
    end else if (timer_wrap || (cmp_match && cmp_special)) begin
      timer_r <= 16'h0000; // see [R11]
    end else begin
      timer_r <= timer_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Compare
  // ----------------------------------------
  // Edge detect so a timer parked on the compare value fires once
  logic match_pulse;
  assign match_pulse = cmp_match && !prev_match_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_match_r <= 1'b0;
      timer_reset <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      prev_match_r <= cmp_match;
      timer_reset <= match_pulse && cmp_special; // see [R11]
      adc_start <= match_pulse && cmp_special && ctrl_r[ccp_pkg::ADC_EN_POS]; // see [R11]
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_event_flag <= 1'b0;
    end else if (unit_off) begin
      match_event_flag <= 1'b0; // see [R02]
    end else if (match_pulse) begin
      match_event_flag <= 1'b1; // see [R04] [R09] [R10] [R15]
    end else if (clr_match) begin
      match_event_flag <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_output_pin <= 1'b0;
    end else if (unit_off) begin
      unit_output_pin <= 1'b0; // see [R02]
    end else if (match_pulse) begin
      case (cmp_action)
        2'h1: unit_output_pin <= !unit_output_pin; // see [R04]
        2'h2: unit_output_pin <= 1'b1; // see [R15]
        2'h3: unit_output_pin <= 1'b0; // see [R09]
        default: unit_output_pin <= unit_output_pin; // see [R10]
      endcase
    end
  end

  // ----------------------------------------
  // Capture
  // ----------------------------------------
  logic [3:0] pre_r;
  logic cap_edge;
  logic cap_take;

  // Two stages settle the pin, the third holds the previous level for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_s1_r <= 1'b0;
      cap_s2_r <= 1'b0;
      cap_s3_r <= 1'b0;
    end else begin
      cap_s1_r <= capture_pin;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
    end
  end

  assign cap_edge = cap_fall ? (cap_s3_r && !cap_s2_r) : (!cap_s3_r && cap_s2_r); // see [R05] [R06]

  assign cap_take = cap_en && cap_edge && pre_r >= cap_last;

  // Prescaler counts qualifying edges; a capture fires on its terminal count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= 4'h0;
    end else if (!cap_en) begin
      pre_r <= 4'h0; // see [R02]
    end else if (cap_take) begin
      pre_r <= 4'h0;
    end else if (cap_edge) begin
      pre_r <= pre_r + 4'h1; // see [R07] [R08]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capt_r <= 16'h0000;
    end else if (unit_off) begin
      capt_r <= 16'h0000; // see [R02]
    end else if (cap_take) begin
      capt_r <= timer_r; // see [R05] [R06] [R07] [R08]
    end
  end

  // Set wins over a clear; a clear is honoured in every cycle without a capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capt_flag_r <= 1'b0;
    end else if (unit_off) begin
      capt_flag_r <= 1'b0; // see [R02]
    end else if (cap_take) begin
      capt_flag_r <= 1'b1;
    end else if (clr_capt) begin
      capt_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // PWM
  // ----------------------------------------
  // Ten-bit duty compared against the timer scaled by four
  logic [9:0] duty10;
  logic [17:0] tick4;
  logic pwm_raw;
  logic [3:0] act;

  assign duty10 = {duty_high_byte, duty_low}; // see [R01]
  assign tick4 = {timer_r, 2'b00};
  assign pwm_raw = pwm_en && (tick4 < {8'h00, duty10});

  // Polarity applies per output after steering, so reverse steering keeps its polarities
  function automatic logic drive_level(input logic active, input logic invert);
    drive_level = active ^ invert;
  endfunction

  // Bridge steering: config 11 is reverse, anything else drives all four modulated
  always_comb begin
    if (outcfg == ccp_pkg::CFG_REVERSE) begin
      act = {1'b0, 1'b1, pwm_raw, 1'b0}; // see [R14]
    end else begin
      act = {4{pwm_raw}};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_a <= 1'b0;
      output_b <= 1'b0;
      output_c <= 1'b0;
      output_d <= 1'b0;
    end else if (!pwm_en) begin
      // Outputs are forced low outside PWM so a mode change never leaves one active
      output_a <= 1'b0;
      output_b <= 1'b0;
      output_c <= 1'b0;
      output_d <= 1'b0;
    end else begin
      output_a <= drive_level(act[0], pwm_invert[0]); // see [R12] [R13] [R16]
      output_b <= drive_level(act[1], pwm_invert[1]);
      output_c <= drive_level(act[2], pwm_invert[2]);
      output_d <= drive_level(act[3], pwm_invert[3]);
    end
  end

endmodule // ccp_unit

// File: rtl/mode_decoder.sv
// Decoder from the four-bit mode field to unit function controls
`timescale 1ns/1ps
module mode_decoder (
  input wire logic [3:0] unit_mode_field,
  output logic unit_off,
  output logic cap_en,
  output logic cap_fall,
  output logic [3:0] cap_last,
  output logic cmp_en,
  output logic [1:0] cmp_action,
  output logic cmp_special,
  output logic pwm_en,
  output logic [3:0] pwm_invert
);

  always_comb begin
    unit_off = 1'b0;
    cap_en = 1'b0;
    cap_fall = 1'b0;
    cap_last = 4'h0;
    cmp_en = 1'b0;
    cmp_action = 2'h0;
    cmp_special = 1'b0;
    pwm_en = 1'b0;
    pwm_invert = 4'h0;
    // Action codes: 0 flag only, 1 toggle, 2 drive high, 3 drive low
    case (unit_mode_field)
      ccp_pkg::M_OFF: unit_off = 1'b1; // see [R02]
      ccp_pkg::M_CMP_TOG: begin // see [R04]
        cmp_en = 1'b1;
        cmp_action = 2'h1;
      end
      ccp_pkg::M_CAP_FALL: begin // see [R05]
        cap_en = 1'b1;
        cap_fall = 1'b1;
      end
      ccp_pkg::M_CAP_RISE: cap_en = 1'b1; // see [R06]
      ccp_pkg::M_CAP_R4: begin // see [R07]
        cap_en = 1'b1;
        cap_last = ccp_pkg::PRE4_LAST;
      end
      ccp_pkg::M_CAP_R16: begin // see [R08]
        cap_en = 1'b1;
        cap_last = ccp_pkg::PRE16_LAST;
      end
      ccp_pkg::M_CMP_SET: begin // see [R15]
        cmp_en = 1'b1;
        cmp_action = 2'h2;
      end
      ccp_pkg::M_CMP_CLR: begin // see [R09]
        cmp_en = 1'b1;
        cmp_action = 2'h3;
      end
      ccp_pkg::M_CMP_FLAG: cmp_en = 1'b1; // see [R10]
      ccp_pkg::M_CMP_SPEC: begin // see [R11]
        cmp_en = 1'b1;
        cmp_special = 1'b1;
      end
      ccp_pkg::M_PWM_HH: pwm_en = 1'b1; // see [R12]
      ccp_pkg::M_PWM_HL: begin // see [R16]
        pwm_en = 1'b1;
        pwm_invert = 4'ha;
      end
      ccp_pkg::M_PWM_LH: begin // see [R16]
        pwm_en = 1'b1;
        pwm_invert = 4'h5;
      end
      ccp_pkg::M_PWM_LL: begin // see [R13]
        pwm_en = 1'b1;
        pwm_invert = 4'hf;
      end
      // Reserved codes select nothing and behave like off without a reset
      default: unit_off = 1'b0; // see [R03]
    endcase
  end

endmodule // mode_decoder

// File: verification/ccp_unit_asserts.sv
// Checker of port behaviour for the capture/compare/PWM unit
`timescale 1ns/1ps
module ccp_unit_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic unit_output_pin,
  input wire logic output_a,
  input wire logic output_b,
  input wire logic output_c,
  input wire logic output_d,
  input wire logic timer_reset,
  input wire logic adc_start
);
  // ----
  // Shadow of mode and duty
  // ----
  logic wr_r;
  logic [7:0] adr_r;
  logic [9:0] ctrl_r;
  logic [7:0] duty_r;
  logic [2:0] quiet_r;
  logic calm;
  logic z;
  logic [3:0] m;
  logic [3:0] outs;
  assign m = ctrl_r[3:0];
  assign outs = {output_a, output_b, output_c, output_d};
  // Outputs lag a write by a few cycles, so checks wait until quiet
  assign calm = quiet_r == 3'h7 && !wr_r;
  assign z = calm && duty_r == 8'h00 && ctrl_r[5:4] == 2'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      adr_r <= 8'h00;
    end else begin
      wr_r <= hsel && hready && htrans[1] && hwrite;
      adr_r <= haddr;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= 10'h000;
      duty_r <= 8'h00;
      quiet_r <= 3'h0;
    end else if (wr_r && adr_r == ccp_pkg::CTRL_OFF) begin
      ctrl_r <= hwdata[9:0];
      quiet_r <= 3'h0;
    end else if (wr_r && adr_r == ccp_pkg::DUTY_OFF) begin
      duty_r <= hwdata[7:0];
      quiet_r <= 3'h0;
    end else if (quiet_r != 3'h7) begin
      quiet_r <= quiet_r + 3'h1;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_off_quiet: assert property (
    calm && m == 4'h0 |-> outs == 4'h0 && !unit_output_pin && !timer_reset)
    else $error("outputs active while off");
  a_pwm_high: assert property (
    z && m == 4'hc && ctrl_r[7:6] != 2'h3 |-> outs == 4'h0)
    else $error("active high outputs wrong at zero duty");
  a_pwm_low: assert property (
    z && m == 4'hf && ctrl_r[7:6] != 2'h3 |-> outs == 4'hf)
    else $error("active low outputs wrong at zero duty");
  a_pwm_mixed: assert property (
    z && ctrl_r[7:6] != 2'h3 && m == 4'hd |-> outs == 4'h5)
    else $error("mixed polarity outputs wrong");
  a_rev_bridge: assert property (
    z && m == 4'hc && ctrl_r[7:6] == 2'h3 |-> outs == 4'h2)
    else $error("reverse bridge outputs wrong");
  a_flag_only: assert property (
    calm && m == 4'ha |=> $stable(unit_output_pin))
    else $error("pin moved in flag only compare");
  a_cmp_low: assert property (
    calm && m == 4'h9 |=> !$rose(unit_output_pin))
    else $error("pin rose in clear on match compare");
  a_cmp_high: assert property (
    calm && m == 4'h8 |=> !$fell(unit_output_pin))
    else $error("pin fell in set on match compare");
  a_adc_with: assert property (
    calm && adc_start |-> timer_reset && ctrl_r[8])
    else $error("conversion start without special event");
  a_special_only: assert property (
    calm && timer_reset |-> m == 4'hb)
    else $error("timer reset outside special event");
  c_special: cover property (calm && m == 4'hb && timer_reset);
  c_toggle: cover property (calm && m == 4'h2 && $changed(unit_output_pin));
  c_low_pwm: cover property (z && m == 4'hf);
endmodule // ccp_unit_asserts

// File: verification/tb_top.sv
// Self-checking bench for the capture/compare/PWM unit
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] cfg;
    logic [9:0] duty;
    logic [3:0] outs;
  } pwm_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic capture_pin = 1'b0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic pin;
  logic [3:0] outs;
  logic trst;
  logic adcs;
  logic [31:0] rd;
  logic last;
  int n;
  int m;
  int miscompares = 0;
  int check_count = 0;
  // Modes 0001 and 0011 are never programmed
  pwm_row_t rows [10] = '{'{4'hc, 2'h0, 10'h000, 4'h0}, '{4'hc, 2'h0, 10'h3ff, 4'hf},
    '{4'hf, 2'h0, 10'h000, 4'hf}, '{4'hf, 2'h0, 10'h3ff, 4'h0},
    '{4'hd, 2'h0, 10'h000, 4'h5}, '{4'he, 2'h0, 10'h000, 4'ha},
    '{4'hc, 2'h3, 10'h000, 4'h2}, '{4'hf, 2'h3, 10'h000, 4'hd},
    '{4'hc, 2'h3, 10'h3ff, 4'h6}, '{4'h0, 2'h0, 10'h3ff, 4'h0}};
  logic [3:0] cmp_m [4] = '{4'h8, 4'ha, 4'h9, 4'ha};
  logic cmp_p [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  logic [3:0] cap_m [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
  int cap_n [4] = '{1, 1, 4, 16};
  always #2.5 hclk = ~hclk;
  assign hready = hreadyout;
  ccp_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .capture_pin(capture_pin),
    .unit_output_pin(pin), .output_a(outs[3]), .output_b(outs[2]), .output_c(outs[1]),
    .output_d(outs[0]), .timer_reset(trst), .adc_start(adcs));
  // ----
  // Tasks
  // ----
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", s, e, g);
      miscompares++;
    end
  endtask
  task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask
  task automatic pin_to(input logic v);
    capture_pin <= v;
    repeat (8) @(posedge hclk);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    report_and_stop();
  end
  // ----
  // Sequence
  // ----
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      bus(1'b1, ccp_pkg::DUTY_OFF, {24'h0, rows[i].duty[9:2]});
      bus(1'b1, ccp_pkg::CTRL_OFF, {24'h0, rows[i].cfg, rows[i].duty[1:0], rows[i].mode});
      repeat (3) begin
        repeat (100) @(posedge hclk);
        chk("pwm outputs", {28'h0, rows[i].outs}, {28'h0, outs});
      end
    end
    // Short period so that each step of the duty high byte adds a quarter of the cycle
    bus(1'b1, ccp_pkg::PERIOD_OFF, 32'h3);
    bus(1'b1, ccp_pkg::CTRL_OFF, 32'h2c);
    for (int k = 1; k < 4; k++) begin
      bus(1'b1, ccp_pkg::DUTY_OFF, 32'(k - 1));
      repeat (8) @(posedge hclk);
      n = 0;
      repeat (400) begin
        @(posedge hclk);
        n += (outs[3] === 1'b1);
      end
      chk("duty count", 32'(100 * k), 32'(n));
    end
    bus(1'b1, ccp_pkg::PERIOD_OFF, 32'hf);
    bus(1'b1, ccp_pkg::CMP_OFF, 32'h5);
    foreach (cmp_m[i]) begin
      bus(1'b1, ccp_pkg::STATUS_OFF, 32'h1);
      bus(1'b1, ccp_pkg::CTRL_OFF, {28'h0, cmp_m[i]});
      repeat (40) @(posedge hclk);
      chk("compare pin", {31'h0, cmp_p[i]}, {31'h0, pin});
      bus(1'b0, ccp_pkg::STATUS_OFF, 32'h0);
      chk("match flag", 32'h1, {31'h0, rd[0]});
    end
    bus(1'b1, ccp_pkg::CTRL_OFF, 32'h2);
    repeat (20) @(posedge hclk);
    n = 0;
    last = pin;
    repeat (160) begin
      @(posedge hclk);
      n += (pin !== last);
      last = pin;
    end
    chk("toggles", 32'h0000_000a, 32'(n));
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, ccp_pkg::CTRL_OFF, {23'h0, k[0], 8'h0b});
      repeat (8) @(posedge hclk);
      n = 0;
      m = 0;
      repeat (100) begin
        @(posedge hclk);
        n += (trst === 1'b1);
        m += (adcs === 1'b1);
      end
      chk("timer resets", 32'h1, 32'(n > 1));
      chk("conversion starts", 32'(k * n), 32'(m));
    end
    bus(1'b1, ccp_pkg::CTRL_OFF, 32'h0);
    repeat (8) @(posedge hclk);
    rdchk("status when off", ccp_pkg::STATUS_OFF, 32'h0);
    rdchk("timer when off", ccp_pkg::TIMER_OFF, 32'h0);
    foreach (cap_m[i]) begin
      bus(1'b1, ccp_pkg::CTRL_OFF, 32'h0);
      bus(1'b1, ccp_pkg::CTRL_OFF, {28'h0, cap_m[i]});
      repeat (cap_n[i] - 1) begin
        pin_to(1'b1);
        pin_to(1'b0);
      end
      bus(1'b0, ccp_pkg::STATUS_OFF, 32'h0);
      chk("capture early", 32'h0, {31'h0, rd[1]});
      pin_to(1'b1);
      bus(1'b0, ccp_pkg::STATUS_OFF, 32'h0);
      chk("capture on rise", {31'h0, cap_m[i] != 4'h4}, {31'h0, rd[1]});
      pin_to(1'b0);
      bus(1'b0, ccp_pkg::STATUS_OFF, 32'h0);
      chk("capture taken", 32'h1, {31'h0, rd[1]});
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk("ctrl after reset", ccp_pkg::CTRL_OFF, 32'h0);
    rdchk("period after reset", ccp_pkg::PERIOD_OFF, 32'hff);
    rdchk("unmapped read", 8'h1c, 32'h0);
    report_and_stop();
  end
endmodule // tb_top

bind ccp_unit ccp_unit_asserts chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .unit_output_pin(unit_output_pin),
  .output_a(output_a), .output_b(output_b), .output_c(output_c), .output_d(output_d),
  .timer_reset(timer_reset), .adc_start(adc_start));
